// File: rtl/dsmr_pkg.sv
package dsmr_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register word addresses
   localparam logic [15:0] ADDR_RUN_STATE_WORD = 16'h2100;
   localparam logic [15:0] ADDR_STATUS_FLAGS_WORD = 16'h2101;
   localparam logic [15:0] ADDR_ACTIVE_FAULT_CODE = 16'h2102;
   localparam logic [15:0] ADDR_DEVICE_IDENTITY = 16'h2103;
   localparam logic [15:0] ADDR_RUNNING_FREQUENCY = 16'h3000;
   localparam logic [15:0] ADDR_SET_FREQUENCY = 16'h3001;
   localparam logic [15:0] ADDR_DC_BUS_VOLTAGE = 16'h3002;
   localparam logic [15:0] ADDR_OUTPUT_VOLTAGE = 16'h3003;
   localparam logic [15:0] ADDR_OUTPUT_CURRENT = 16'h3004;
   localparam logic [15:0] ADDR_SHAFT_SPEED = 16'h3005;
   localparam logic [15:0] ADDR_OUTPUT_POWER = 16'h3006;
   localparam logic [15:0] ADDR_OUTPUT_TORQUE = 16'h3007;
   localparam logic [15:0] ADDR_LOOP_SETPOINT = 16'h3008;
   localparam logic [15:0] ADDR_LOOP_FEEDBACK = 16'h3009;
   localparam logic [15:0] ADDR_DIGITAL_INPUT_IMAGE = 16'h300a;
   localparam logic [15:0] ADDR_DIGITAL_OUTPUT_IMAGE = 16'h300b;
   localparam logic [15:0] ADDR_ANALOG_IN_ONE = 16'h300c;
   localparam logic [15:0] ADDR_ANALOG_IN_TWO = 16'h300d;
   localparam logic [15:0] ADDR_ANALOG_IN_THREE = 16'h300e;
   localparam logic [15:0] ADDR_ANALOG_IN_FOUR = 16'h300f;
   localparam logic [15:0] ADDR_PULSE_IN_ONE_FREQ = 16'h3010;
   localparam logic [15:0] ADDR_PULSE_IN_TWO_FREQ = 16'h3011;
   localparam logic [15:0] ADDR_SPEED_STEP_INDEX = 16'h3012;
   localparam logic [15:0] ADDR_EXTERNAL_LENGTH = 16'h3013;
   localparam logic [15:0] ADDR_EXTERNAL_COUNT = 16'h3014;
   localparam logic [15:0] ADDR_TORQUE_REFERENCE = 16'h3015;
   localparam logic [15:0] ADDR_IDENTITY_ALIAS = 16'h3016;
   localparam logic [15:0] ADDR_FAULT_CODE_ALIAS = 16'h5000;

   ////////////////////////////////////////////////////////////////////////////
   // Run state word codes
   localparam logic [15:0] RUN_CODE_FORWARD = 16'h0001;
   localparam logic [15:0] RUN_CODE_REVERSE = 16'h0002;
   localparam logic [15:0] RUN_CODE_STOPPED = 16'h0003;
   localparam logic [15:0] RUN_CODE_FAULTY = 16'h0004;
   localparam logic [15:0] RUN_CODE_POWER_OFF = 16'h0005;
   localparam logic [15:0] RUN_CODE_PRE_EXCITED = 16'h0006;

   ////////////////////////////////////////////////////////////////////////////
   // Status flags word bit positions
   localparam int FLAG_READY_BIT = 0;
   localparam int FLAG_MOTOR_LO_BIT = 1;
   localparam int FLAG_MOTOR_HI_BIT = 2;
   localparam int FLAG_SYNC_MOTOR_BIT = 3;
   localparam int FLAG_OVERLOAD_BIT = 4;
   localparam int FLAG_SOURCE_LO_BIT = 5;
   localparam int FLAG_SOURCE_HI_BIT = 6;
   localparam int FLAG_TORQUE_MODE_BIT = 8;
   localparam int FLAG_POSITION_BIT = 9;
   localparam int FLAG_METHOD_LO_BIT = 10;
   localparam int FLAG_METHOD_HI_BIT = 11;

   ////////////////////////////////////////////////////////////////////////////
   // Limits of the monitor words in counts, and field widths in bits
   localparam logic [15:0] BUS_VOLT_MAX = 16'h4e20;
   localparam logic signed [15:0] POWER_LIMIT = 16'sh0bb8;
   localparam logic signed [15:0] TORQUE_LIMIT = 16'sh09c4;
   localparam logic signed [15:0] LOOP_LIMIT = 16'sh03e8;
   localparam logic signed [15:0] TORQUE_REF_LIMIT = 16'sh0bb8;
   localparam int STEP_INDEX_WIDTH = 4;
   localparam int INPUT_IMAGE_WIDTH = 6;
   localparam int OUTPUT_IMAGE_WIDTH = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Fieldbus scale divisors by number of decimals
   localparam logic [15:0] SCALE_DIV_0 = 16'h0001;
   localparam logic [15:0] SCALE_DIV_1 = 16'h000a;
   localparam logic [15:0] SCALE_DIV_2 = 16'h0064;
   localparam logic [15:0] SCALE_DIV_3 = 16'h03e8;

   // Answer codes: none, or the refusal reason
   localparam logic [7:0] ERR_NONE = 8'h00;
   localparam logic [7:0] ERR_BAD_ADDRESS = 8'h02;
   localparam logic [7:0] ERR_READ_ONLY = 8'h07;

   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [2:0] {
      DSMR_RUN_FORWARD = 3'b001,
      DSMR_RUN_REVERSE = 3'b010,
      DSMR_RUN_STOPPED = 3'b011,
      DSMR_RUN_FAULTY = 3'b100,
      DSMR_RUN_POWER_OFF = 3'b101,
      DSMR_RUN_PRE_EXCITED = 3'b110
   } dsmr_run_t;

   typedef struct packed {
      dsmr_run_t run_state;
      logic ready;
      logic [1:0] motor_sel;
      logic sync_motor;
      logic overload;
      logic [1:0] ctrl_source;
      logic torque_mode;
      logic position_mode;
      logic [1:0] ctrl_method;
      logic [15:0] fault_code;
   } dsmr_state_t;

   typedef struct packed {
      logic fast_pulse_input_b;
      logic fast_pulse_input_a;
      logic switch_input_four;
      logic switch_input_three;
      logic switch_input_two;
      logic switch_input_one;
      logic relay_output_two;
      logic relay_output_one;
      logic fast_pulse_output;
      logic transistor_output_one;
   } dsmr_pins_t;

   typedef struct packed {
      logic [15:0] run_freq;
      logic [15:0] set_freq;
      logic [15:0] bus_volt;
      logic [15:0] out_volt;
      logic [15:0] out_curr;
      logic [15:0] speed;
      logic signed [15:0] power;
      logic signed [15:0] torque;
      logic signed [15:0] loop_set;
      logic signed [15:0] loop_fb;
      logic [15:0] analog_one;
      logic [15:0] analog_two;
      logic signed [15:0] analog_three;
      logic [15:0] analog_four;
      logic [15:0] pulse_one;
      logic [15:0] pulse_two;
      logic [15:0] step_index;
      logic [15:0] ext_length;
      logic [15:0] ext_count;
      logic signed [15:0] torque_ref;
   } dsmr_meas_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [15:0] addr;
      logic [15:0] data;
      logic [1:0] decimals;
   } dsmr_req_t;

   typedef struct packed {
      logic valid;
      logic error;
      logic [7:0] code;
      logic [15:0] data;
   } dsmr_rsp_t;

   typedef struct packed {
      logic valid;
      logic [15:0] addr;
      logic [15:0] whole;
      logic [15:0] frac;
   } dsmr_param_t;

endpackage : dsmr_pkg

// File: rtl/dsmr_regs.sv
// What this block does
// - Stopped drive reads run word 0003h
// - Flags bit 0 shows ready to run
// - Flags bits 2..1 show active motor set
// - Flags bit 3 shows synchronous motor
// - Flags bit 4 shows overload alarm
// - Flags bit 8 shows torque control
// - Flags bit 9 shows position control
// - Flags bits 11..10 show control method
// - Read-only words refuse writes; writes use 06h
// - Identity word: family high, model low
// - Decimals scaled by ten to decimal count
// - Written integer divided by scale when stored
// - Bus voltage 0..2000.0 V, 0.1 V counts
// - Loop feedback signed +-100.0 percent
// - Speed step index reads 0..15
// - Output image: one bit per output
`timescale 1ns/10ps

module dsmr_regs #(
   parameter logic [7:0] FAMILY_CODE = 8'h5a, // Arbitrary value
   parameter logic [7:0] MODEL_CODE = 8'h3c   // Arbitrary value
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Drive condition and measurements
   input dsmr_pkg::dsmr_state_t state_i,
   input dsmr_pkg::dsmr_pins_t pins_i,
   input dsmr_pkg::dsmr_meas_t meas_i,
   // Register requests from the link
   input dsmr_pkg::dsmr_req_t req_i,
   output dsmr_pkg::dsmr_rsp_t rsp_o,
   // Parameter writes toward the parameter store
   output dsmr_pkg::dsmr_param_t param_o
);
   import dsmr_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Saturate a signed quantity to a symmetric limit
   function automatic logic [15:0] clamp_signed(
      input logic signed [15:0] value,
      input logic signed [15:0] limit
   );
      logic signed [15:0] neg_limit;
      neg_limit = -limit;
      if (value > limit) begin
         clamp_signed = limit;
      end else if (value < neg_limit) begin
         clamp_signed = neg_limit;
      end else begin
         clamp_signed = value;
      end
   endfunction : clamp_signed

   // Saturate an unsigned quantity to an upper limit
   function automatic logic [15:0] clamp_unsigned(
      input logic [15:0] value,
      input logic [15:0] limit
   );
      clamp_unsigned = (value > limit) ? limit : value;
   endfunction : clamp_unsigned

   // Divisor for a given number of decimals
   function automatic logic [15:0] scale_of(input logic [1:0] decimals);
      logic [15:0] div;
      unique case (decimals)
         2'b00: div = SCALE_DIV_0;
         2'b01: div = SCALE_DIV_1;
         2'b10: div = SCALE_DIV_2;
         2'b11: div = SCALE_DIV_3;
      endcase
      scale_of = div;
   endfunction : scale_of

   // Run state to its word code
   function automatic logic [15:0] run_code(input dsmr_run_t run);
      logic [15:0] code;
      unique case (run)
         DSMR_RUN_FORWARD: code = RUN_CODE_FORWARD;
         DSMR_RUN_REVERSE: code = RUN_CODE_REVERSE;
         DSMR_RUN_STOPPED: code = RUN_CODE_STOPPED;
         DSMR_RUN_FAULTY: code = RUN_CODE_FAULTY;
         DSMR_RUN_POWER_OFF: code = RUN_CODE_POWER_OFF;
         DSMR_RUN_PRE_EXCITED: code = RUN_CODE_PRE_EXCITED;
         default: code = RUN_CODE_STOPPED;
      endcase
      run_code = code;
   endfunction : run_code

   ////////////////////////////////////////////////////////////////////////////
   // Word assembly

   wire logic [15:0] run_word;
   wire logic [15:0] flags_word;
   wire logic [15:0] ident_word;
   wire logic [15:0] bus_volt_word;
   wire logic [15:0] power_word;
   wire logic [15:0] torque_word;
   wire logic [15:0] loop_set_word;
   wire logic [15:0] loop_fb_word;
   wire logic [15:0] torque_ref_word;
   wire logic [15:0] step_word;
   wire logic [15:0] in_image_word;
   wire logic [15:0] out_image_word;

   assign run_word = run_code(state_i.run_state);

   assign flags_word = {
      4'h0,
      state_i.ctrl_method,
      state_i.position_mode,
      state_i.torque_mode,
      1'b0,
      state_i.ctrl_source,
      state_i.overload,
      state_i.sync_motor,
      state_i.motor_sel,
      state_i.ready
   };

   assign ident_word = {FAMILY_CODE, MODEL_CODE};

   assign bus_volt_word = clamp_unsigned(meas_i.bus_volt, BUS_VOLT_MAX);

   // Signed words except analog input three saturate at their legal span
   assign power_word = clamp_signed(meas_i.power, POWER_LIMIT);
   assign torque_word = clamp_signed(meas_i.torque, TORQUE_LIMIT);
   assign loop_set_word = clamp_signed(meas_i.loop_set, LOOP_LIMIT);
   assign loop_fb_word = clamp_signed(meas_i.loop_fb, LOOP_LIMIT);
   assign torque_ref_word = clamp_signed(meas_i.torque_ref, TORQUE_REF_LIMIT);

   assign step_word = {12'h000, meas_i.step_index[STEP_INDEX_WIDTH-1:0]};

   assign in_image_word = {
      10'h000,
      pins_i.fast_pulse_input_b,
      pins_i.fast_pulse_input_a,
      pins_i.switch_input_four,
      pins_i.switch_input_three,
      pins_i.switch_input_two,
      pins_i.switch_input_one
   };

   assign out_image_word = {
      12'h000,
      pins_i.relay_output_two,
      pins_i.relay_output_one,
      pins_i.fast_pulse_output,
      pins_i.transistor_output_one
   };

   ////////////////////////////////////////////////////////////////////////////
   // Address decode and read selection

   logic [15:0] read_word;
   logic bank_hit;

   always_comb begin
      bank_hit = 1'b1;
      read_word = 16'h0000;
      unique case (req_i.addr)
         ADDR_RUN_STATE_WORD: read_word = run_word;
         ADDR_STATUS_FLAGS_WORD: read_word = flags_word;
         ADDR_ACTIVE_FAULT_CODE: read_word = state_i.fault_code;
         ADDR_DEVICE_IDENTITY: read_word = ident_word;
         ADDR_RUNNING_FREQUENCY: read_word = meas_i.run_freq;
         ADDR_SET_FREQUENCY: read_word = meas_i.set_freq;
         ADDR_DC_BUS_VOLTAGE: read_word = bus_volt_word;
         ADDR_OUTPUT_VOLTAGE: read_word = meas_i.out_volt;
         ADDR_OUTPUT_CURRENT: read_word = meas_i.out_curr;
         ADDR_SHAFT_SPEED: read_word = meas_i.speed;
         ADDR_OUTPUT_POWER: read_word = power_word;
         ADDR_OUTPUT_TORQUE: read_word = torque_word;
         ADDR_LOOP_SETPOINT: read_word = loop_set_word;
         ADDR_LOOP_FEEDBACK: read_word = loop_fb_word;
         ADDR_DIGITAL_INPUT_IMAGE: read_word = in_image_word;
         ADDR_DIGITAL_OUTPUT_IMAGE: read_word = out_image_word;
         ADDR_ANALOG_IN_ONE: read_word = meas_i.analog_one;
         ADDR_ANALOG_IN_TWO: read_word = meas_i.analog_two;
         ADDR_ANALOG_IN_THREE: read_word = meas_i.analog_three;
         ADDR_ANALOG_IN_FOUR: read_word = meas_i.analog_four;
         ADDR_PULSE_IN_ONE_FREQ: read_word = meas_i.pulse_one;
         ADDR_PULSE_IN_TWO_FREQ: read_word = meas_i.pulse_two;
         ADDR_SPEED_STEP_INDEX: read_word = step_word;
         ADDR_EXTERNAL_LENGTH: read_word = meas_i.ext_length;
         ADDR_EXTERNAL_COUNT: read_word = meas_i.ext_count;
         ADDR_TORQUE_REFERENCE: read_word = torque_ref_word;
         ADDR_IDENTITY_ALIAS: read_word = ident_word;
         ADDR_FAULT_CODE_ALIAS: read_word = state_i.fault_code;
         default: bank_hit = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Request classification

   wire logic read_req;
   wire logic write_req;
   wire logic read_ok;
   wire logic read_bad;
   wire logic write_refused;
   wire logic param_write;

   assign read_req = req_i.valid && !req_i.write;
   assign write_req = req_i.valid && req_i.write;
   assign read_ok = read_req && bank_hit;
   assign read_bad = read_req && !bank_hit;
   // Every bank word is read only, so a write to one is refused
   assign write_refused = write_req && bank_hit;
   // Writes outside the bank go on to the parameter store
   assign param_write = write_req && !bank_hit;

   ////////////////////////////////////////////////////////////////////////////
   // Fieldbus scale: integer back to engineering whole and fraction

   wire logic [15:0] divisor;
   wire logic [15:0] quotient;
   wire logic [15:0] remainder;

   assign divisor = scale_of(req_i.decimals);
   assign quotient = req_i.data / divisor;
   assign remainder = req_i.data % divisor;

   ////////////////////////////////////////////////////////////////////////////
   // Answer

   dsmr_rsp_t rsp_reg;
   dsmr_rsp_t rsp_next;

   always_comb begin
      rsp_next.valid = req_i.valid;
      rsp_next.error = read_bad || write_refused;
      rsp_next.code = ERR_NONE;
      rsp_next.data = 16'h0000;
      if (read_ok) begin
         rsp_next.data = read_word;
      end else if (read_bad) begin
         rsp_next.code = ERR_BAD_ADDRESS;
      end else if (write_refused) begin
         rsp_next.code = ERR_READ_ONLY;
      end else if (param_write) begin
         // Accepted writes echo the data, as a write answer does
         rsp_next.data = req_i.data;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         rsp_reg <= '0;
      end else begin
         rsp_reg <= rsp_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Parameter store write

   dsmr_param_t param_reg;
   dsmr_param_t param_next;

   always_comb begin
      param_next.valid = param_write;
      param_next.addr = param_write ? req_i.addr : param_reg.addr;
      param_next.whole = param_write ? quotient : param_reg.whole;
      param_next.frac = param_write ? remainder : param_reg.frac;
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         param_reg <= '0;
      end else begin
         param_reg <= param_next;
      end
   end

   assign rsp_o = rsp_reg;
   assign param_o = param_reg;

endmodule : dsmr_regs

// File: bench/dsmr_regs_props.sv
`timescale 1ns/10ps

module dsmr_regs_props #(
   parameter logic [7:0] FAMILY_CODE = 8'h5a, // Arbitrary value
   parameter logic [7:0] MODEL_CODE = 8'h3c // Arbitrary value
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Watched ports of the block
   input dsmr_pkg::dsmr_state_t state_i,
   input dsmr_pkg::dsmr_pins_t pins_i,
   input dsmr_pkg::dsmr_meas_t meas_i,
   input dsmr_pkg::dsmr_req_t req_i,
   input dsmr_pkg::dsmr_rsp_t rsp_o,
   input dsmr_pkg::dsmr_param_t param_o
);
   import dsmr_pkg::*;
   wire in_map;
   logic [15:0] scale_div;
   logic [15:0] volt_sat;
   logic signed [15:0] fb_sat;
   assign in_map = (req_i.addr >= ADDR_RUN_STATE_WORD && req_i.addr <= ADDR_DEVICE_IDENTITY)
      || (req_i.addr >= ADDR_RUNNING_FREQUENCY && req_i.addr <= ADDR_IDENTITY_ALIAS)
      || (req_i.addr == ADDR_FAULT_CODE_ALIAS);
   assign scale_div = (req_i.decimals == 2'h0) ? SCALE_DIV_0 : (req_i.decimals == 2'h1) ?
      SCALE_DIV_1 : (req_i.decimals == 2'h2) ? SCALE_DIV_2 : SCALE_DIV_3;
   assign volt_sat = (meas_i.bus_volt > BUS_VOLT_MAX) ? BUS_VOLT_MAX : meas_i.bus_volt;
   assign fb_sat = (meas_i.loop_fb > LOOP_LIMIT) ? LOOP_LIMIT :
      (meas_i.loop_fb < -LOOP_LIMIT) ? -LOOP_LIMIT : meas_i.loop_fb;
   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_read(logic [15:0] a);
      req_i.valid && !req_i.write && req_i.addr == a;
   endsequence
   sequence s_flags;
      s_read(ADDR_STATUS_FLAGS_WORD);
   endsequence
   sequence s_ok;
      rsp_o.valid && !rsp_o.error;
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   a_run_stopped: assert property (s_read(ADDR_RUN_STATE_WORD) ##0
      state_i.run_state == DSMR_RUN_STOPPED |=> s_ok ##0 rsp_o.data == 16'h0003)
      else $error("stopped drive not read as 0003");
   a_ready_flag: assert property (s_flags |=> rsp_o.data[0] == $past(state_i.ready))
      else $error("ready flag wrong");
   a_motor_set: assert property (s_flags |=> rsp_o.data[2:1] == $past(state_i.motor_sel))
      else $error("motor set field wrong");
   a_sync_motor: assert property (s_flags |=> rsp_o.data[3] == $past(state_i.sync_motor))
      else $error("motor kind flag wrong");
   a_overload_flag: assert property (s_flags |=> rsp_o.data[4] == $past(state_i.overload))
      else $error("overload flag wrong");
   a_torque_mode: assert property (s_flags |=> rsp_o.data[8] == $past(state_i.torque_mode))
      else $error("torque mode flag wrong");
   a_position_mode: assert property (s_flags |=> rsp_o.data[9] == $past(state_i.position_mode))
      else $error("position flag wrong");
   a_ctrl_method: assert property (s_flags |=> s_ok ##0
      rsp_o.data[11:10] == $past(state_i.ctrl_method)) else $error("method field wrong");
   a_ro_refused: assert property (req_i.valid && req_i.write && in_map |=>
      rsp_o.valid && rsp_o.error && rsp_o.code == ERR_READ_ONLY && !param_o.valid)
      else $error("write to read-only word not refused");
   a_identity_word: assert property (s_read(ADDR_DEVICE_IDENTITY) |=> s_ok ##0
      rsp_o.data == {FAMILY_CODE, MODEL_CODE}) else $error("identity word wrong");
   a_param_scale: assert property (req_i.valid && req_i.write && !in_map |=>
      param_o.valid && param_o.whole == $past(req_i.data) / $past(scale_div)
      && param_o.frac == $past(req_i.data) % $past(scale_div)) else $error("scaling wrong");
   a_bus_volt: assert property (s_read(ADDR_DC_BUS_VOLTAGE) |=>
      rsp_o.data == $past(volt_sat)) else $error("bus voltage word wrong");
   a_loop_feedback: assert property (s_read(ADDR_LOOP_FEEDBACK) |=>
      rsp_o.data == $past(fb_sat)) else $error("loop feedback word wrong");
   a_step_index: assert property (s_read(ADDR_SPEED_STEP_INDEX) |=>
      rsp_o.data == {12'h000, $past(meas_i.step_index[3:0])}) else $error("step index wrong");
   a_output_image: assert property (s_read(ADDR_DIGITAL_OUTPUT_IMAGE) |=>
      rsp_o.data == {12'h000, $past(pins_i[3:0])}) else $error("output image wrong");
   a_answer_once: assert property (rsp_o.valid |-> $past(req_i.valid))
      else $error("answer without request");
endmodule : dsmr_regs_props

bind dsmr_regs dsmr_regs_props #(.FAMILY_CODE(FAMILY_CODE), .MODEL_CODE(MODEL_CODE))
   i_dsmr_regs_props (.clk_i(clk_i), .reset_n_i(reset_n_i), .state_i(state_i),
   .pins_i(pins_i), .meas_i(meas_i), .req_i(req_i), .rsp_o(rsp_o), .param_o(param_o));

// File: bench/dsmr_master_model.sv
`timescale 1ns/10ps

module dsmr_master_model (
   // Clock
   input wire logic clk_i,
   // Request toward the register block
   output dsmr_pkg::dsmr_req_t req_o,
   // Answers from the register block
   input dsmr_pkg::dsmr_rsp_t rsp_i,
   input dsmr_pkg::dsmr_param_t param_i
);
   import dsmr_pkg::*;
   dsmr_rsp_t last_rsp;
   dsmr_param_t last_param;
   initial req_o = '0;
   // One request per call; the caller has already scaled data by its decimals
   task automatic xfer(input logic [7:0] func, input logic [15:0] addr,
      input logic [15:0] data, input logic [1:0] dec, input int idle);
      repeat (idle) @(negedge clk_i);
      @(negedge clk_i);
      req_o.valid = 1'b1;
      req_o.write = (func == 8'h06);
      req_o.addr = addr;
      req_o.data = data;
      req_o.decimals = dec;
      @(negedge clk_i);
      last_rsp = rsp_i;
      last_param = param_i;
      // Released address and data lines carry inverted values; write and decimals keep theirs
      req_o.valid = 1'b0;
      req_o.addr = ~addr;
      req_o.data = ~data;
   endtask : xfer
endmodule : dsmr_master_model

// File: bench/dsmr_regs_tb_top.sv
`timescale 1ns/10ps

module dsmr_regs_tb_top;
   import dsmr_pkg::*;
   localparam logic [7:0] FAMILY = 8'h6b; // Arbitrary value
   localparam logic [7:0] MODEL = 8'h2d; // Arbitrary value
   localparam logic [7:0] FC_READ = 8'h03;
   localparam logic [7:0] FC_WRITE = 8'h06;
   logic clk_i;
   logic reset_n_i;
   dsmr_state_t state_i;
   dsmr_pins_t pins_i;
   dsmr_meas_t meas_i;
   dsmr_req_t req_i;
   dsmr_rsp_t rsp_o;
   dsmr_param_t param_o;
   dsmr_rsp_t r;
   dsmr_param_t p;
   int fail_count;
   int samples_checked;

   dsmr_regs #(.FAMILY_CODE(FAMILY), .MODEL_CODE(MODEL)) i_dsmr_regs (.clk_i(clk_i),
      .reset_n_i(reset_n_i), .state_i(state_i), .pins_i(pins_i), .meas_i(meas_i),
      .req_i(req_i), .rsp_o(rsp_o), .param_o(param_o));
   dsmr_master_model i_dsmr_master_model (.clk_i(clk_i), .req_o(req_i), .rsp_i(rsp_o),
      .param_i(param_o));

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic xfer(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] d,
      input logic [1:0] dec);
      i_dsmr_master_model.xfer(fc, a, d, dec, 0);
      r = i_dsmr_master_model.last_rsp;
      p = i_dsmr_master_model.last_param;
      check("answer valid", 16'(r.valid), 16'h0001);
   endtask : xfer

   task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp, input string what);
      xfer(FC_READ, a, 16'h0000, 2'h0);
      check(what, r.data, exp);
   endtask : rd_chk

   task automatic wr_chk(input logic [15:0] d, input logic [1:0] dec, input logic [15:0] w,
      input logic [15:0] f);
      xfer(FC_WRITE, 16'h0114, d, dec);
      check("param valid", 16'(p.valid), 16'h0001);
      check("param addr", p.addr, 16'h0114);
      check("param whole", p.whole, w);
      check("param frac", p.frac, f);
      check("write echo", r.data, d);
   endtask : wr_chk
   ////////////////////////////////////////////////////////////////////////////
   task automatic test_run_codes;
      for (int k = 1; k <= 6; k++) begin
         state_i.run_state = dsmr_run_t'(k);
         rd_chk(ADDR_RUN_STATE_WORD, 16'(k), "run word");
      end
      $display("test run_codes done");
   endtask : test_run_codes

   task automatic test_flags;
      logic [1:0] v;
      for (int i = 0; i < 4; i++) begin
         v = 2'(i);
         state_i.ready = v[0];
         state_i.motor_sel = v;
         state_i.sync_motor = ~v[0];
         state_i.overload = v[1];
         state_i.ctrl_source = v;
         state_i.torque_mode = v[1] ^ v[0];
         state_i.position_mode = ~v[1];
         state_i.ctrl_method = v;
         rd_chk(ADDR_STATUS_FLAGS_WORD, {4'h0, v, ~v[1], v[1] ^ v[0], 1'b0, v, v[1], ~v[0], v,
            v[0]}, "flags word");
      end
      $display("test flags done");
   endtask : test_flags

   task automatic test_ident;
      state_i.fault_code = 16'h002a;
      rd_chk(ADDR_DEVICE_IDENTITY, {FAMILY, MODEL}, "identity");
      rd_chk(ADDR_IDENTITY_ALIAS, {FAMILY, MODEL}, "identity alias");
      rd_chk(ADDR_ACTIVE_FAULT_CODE, 16'h002a, "fault code");
      rd_chk(ADDR_FAULT_CODE_ALIAS, 16'h002a, "fault alias");
      $display("test ident done");
   endtask : test_ident

   task automatic test_meas;
      meas_i.bus_volt = 16'h4e20;
      rd_chk(ADDR_DC_BUS_VOLTAGE, 16'h4e20, "bus volt top");
      meas_i.bus_volt = 16'h4e21;
      rd_chk(ADDR_DC_BUS_VOLTAGE, 16'h4e20, "bus volt clamp");
      meas_i.loop_fb = 16'hfc18;
      rd_chk(ADDR_LOOP_FEEDBACK, 16'hfc18, "loop fb low");
      meas_i.loop_fb = 16'hfc17;
      rd_chk(ADDR_LOOP_FEEDBACK, 16'hfc18, "loop fb clamp");
      meas_i.loop_fb = 16'h03e9;
      rd_chk(ADDR_LOOP_FEEDBACK, 16'h03e8, "loop fb high");
      meas_i.step_index = 16'h000f;
      rd_chk(ADDR_SPEED_STEP_INDEX, 16'h000f, "step index");
      pins_i.relay_output_two = 1'b1;
      pins_i.transistor_output_one = 1'b1;
      pins_i.fast_pulse_input_b = 1'b1;
      rd_chk(ADDR_DIGITAL_OUTPUT_IMAGE, 16'h0009, "output image");
      rd_chk(ADDR_DIGITAL_INPUT_IMAGE, 16'h0020, "input image");
      $display("test meas done");
   endtask : test_meas

   task automatic test_signed;
      meas_i.power = 16'h0bb9;
      meas_i.torque = 16'hf63b;
      meas_i.loop_set = 16'hfc18;
      meas_i.torque_ref = 16'hf447;
      meas_i.ext_count = 16'hffff;
      meas_i.run_freq = 16'h1394;
      rd_chk(ADDR_OUTPUT_POWER, 16'h0bb8, "power clamp");
      rd_chk(ADDR_OUTPUT_TORQUE, 16'hf63c, "torque clamp");
      rd_chk(ADDR_LOOP_SETPOINT, 16'hfc18, "loop set low");
      rd_chk(ADDR_TORQUE_REFERENCE, 16'hf448, "torque ref clamp");
      rd_chk(ADDR_EXTERNAL_COUNT, 16'hffff, "ext count");
      rd_chk(ADDR_RUNNING_FREQUENCY, 16'h1394, "run freq");
      $display("test signed done");
   endtask : test_signed

   task automatic test_refusals;
      xfer(FC_WRITE, ADDR_STATUS_FLAGS_WORD, 16'h0001, 2'h0);
      check("ro error", {r.error, 7'h00, r.code}, 16'h8007);
      check("ro no param", 16'(p.valid), 16'h0000);
      xfer(FC_WRITE, ADDR_FAULT_CODE_ALIAS, 16'h0001, 2'h0);
      check("ro alias error", {r.error, 7'h00, r.code}, 16'h8007);
      xfer(FC_READ, 16'h2104, 16'h0000, 2'h0);
      check("bad addr", {r.error, 7'h00, r.code}, 16'h8002);
      check("bad addr data", r.data, 16'h0000);
      $display("test refusals done");
   endtask : test_refusals

   task automatic test_scale;
      wr_chk(16'h0032, 2'h1, 16'h0005, 16'h0000);
      wr_chk(16'h1394, 2'h2, 16'h0032, 16'h000c);
      wr_chk(16'h1394, 2'h3, 16'h0005, 16'h000c);
      wr_chk(16'h0007, 2'h0, 16'h0007, 16'h0000);
      $display("test scale done");
   endtask : test_scale
   ////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : give_verdict

   initial begin
      fail_count = 0;
      samples_checked = 0;
      reset_n_i = 1'b0;
      state_i = '0;
      state_i.run_state = DSMR_RUN_STOPPED;
      pins_i = '0;
      meas_i = '0;
      repeat (10) @(negedge clk_i);
      reset_n_i = 1'b1;
      test_run_codes();
      test_flags();
      test_ident();
      test_meas();
      test_signed();
      test_refusals();
      test_scale();
      give_verdict();
   end

   initial begin
      repeat (2000) @(posedge clk_i);
      fail_count++;
      give_verdict();
   end
endmodule : dsmr_regs_tb_top
